// [npl_map.vh]
`ifndef NPL_MAP_VH
`define NPL_MAP_VH
// ----------------------------------------
// Page layout
// ----------------------------------------
`define NPL_SPARE_START 12'h800
`define NPL_BBM_LAST 12'h803
`define NPL_META1_START 12'h820
`define NPL_ECC_START 12'h840
`define NPL_ECC_LAST 12'h87f
`define NPL_ECC_PER_SECT 12'h010
`define NPL_META1_PER_SECT 12'h008
`define NPL_SECT_BYTES 12'h200
`define NPL_PAGE_LAST 12'h87f
`define NPL_GOOD_MARK 8'hff
`define NPL_BAD_MARK 8'h00
`define NPL_MAX_CORR 4'h8
`define NPL_MAIN_SECT_HI 10
`define NPL_MAIN_SECT_LO 9
`define NPL_META1_SECT_HI 4
`define NPL_META1_SECT_LO 3
`define NPL_ECC_SECT_HI 5
`define NPL_ECC_SECT_LO 4
// ----------------------------------------
// Status bits and timing
// ----------------------------------------
`define NPL_STAT_BUSY_BIT 0
`define NPL_INIT_TIME_US 1250
`define NPL_CLK_MHZ 10
`endif

// [npl_sync3.v]
`timescale 1ns/1ps
module npl_sync3 (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Async input and filtered level
    input wire din,
    output reg dout
);
reg s1_r;
reg s2_r;
reg s3_r;
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        dout <= 1'b0;
    end else begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
end
endmodule // npl_sync3

// [npl_nand_powerup.v]
// Functional notes
// RULE1: ECC parity for sector n sits at 840h+16n, user writes there refused.
// RULE2: Spare bytes 800h..803h hold bad-block mark, outside ECC coverage.
// RULE3: Codeword is 512 main plus 8 meta plus 16 parity bytes, 8-bit correction.
// RULE4: Bad factory block has 00h at byte 2048 of page one or two.
// RULE5: Host scans first spare byte of pages one and two for non-FFh; block_bad checks byte 800h of the first page only.
// RULE6: Host tolerates up to total minus minimum valid blocks going bad.
// RULE7: Host keeps chip select inactive during supply ramps.
// RULE8: Host waits 250 us after write-inhibit level before explicit reset.
// RULE9: Host sends nothing for 1.25 ms after reset unless polling busy.
// RULE10: Device starts initialization alone once supply passes write-inhibit level.
// RULE11: Initialization loads first array page into cache register.
// RULE12: Status reads accepted during initialization; host polls busy until clear.
// RULE13: Non-polling host waits 1.25 ms after minimum supply before access.
// RULE14: Status bit 0 is one while busy, zero when ready.
// RULE15: Host rounds its wait counts up so no wait is short.
`timescale 1ns/1ps
`include "npl_map.vh"
module npl_nand_powerup #(
    parameter INIT_CYCLES = `NPL_INIT_TIME_US * `NPL_CLK_MHZ,
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Supply monitor
    input wire write_inhibit_level,
    // Host reset command and status read
    input wire reset_cmd,
    input wire status_rd,
    output reg [7:0] status_q,
    output reg status_vld,
    // Array read port for first page
    output reg arr_rd,
    output reg [11:0] arr_addr,
    input wire [7:0] arr_data,
    // Cache register write port
    output reg cache_wr,
    output reg [11:0] cache_addr,
    output reg [7:0] cache_data,
    // Page layout classification of a user write address
    input wire [11:0] chk_addr,
    output reg chk_ecc_cov,
    output reg chk_wr_refused,
    output reg [1:0] chk_sector,
    // Bad block report of loaded first page
    output reg block_bad,
    // Busy flag
    output reg busy_in_progress_flag
);
// ----------------------------------------
// States
// ----------------------------------------
localparam [3:0] ST_OFF = 4'h1;
localparam [3:0] ST_LOAD = 4'h2;
localparam [3:0] ST_WAIT = 4'h4;
localparam [3:0] ST_RDY = 4'h8;
localparam [CNT_W-1:0] INIT_CNT = INIT_CYCLES[CNT_W-1:0];
reg [3:0] state_r;
reg [3:0] state_nxt;
reg [CNT_W-1:0] cnt_r;
reg [11:0] addr_r;
reg rd_dly_r;
reg [11:0] rd_addr_dly_r;
wire wi_ok;
wire rst_cmd_ok;
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
npl_sync3 u_sync_wi (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din(write_inhibit_level),
    .dout(wi_ok)
);
npl_sync3 u_sync_rst (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .din(reset_cmd),
    .dout(rst_cmd_ok)
);
reg rst_cmd_d_r;
wire rst_cmd_pulse;
assign rst_cmd_pulse = rst_cmd_ok & ~rst_cmd_d_r;
wire pipe_idle;
assign pipe_idle = ~arr_rd & ~rd_dly_r & ~cache_wr;
// ----------------------------------------
// Init sequencer
// ----------------------------------------
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_OFF: begin
            if (wi_ok) begin
                state_nxt = ST_LOAD; // RULE10
            end
        end
        ST_LOAD: begin
            if (addr_r == `NPL_PAGE_LAST) begin
                state_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (cnt_r == {CNT_W{1'b0}} && pipe_idle) begin
                state_nxt = ST_RDY;
            end
        end
        ST_RDY: begin
            if (rst_cmd_pulse) begin
                state_nxt = ST_LOAD;
            end
        end
        default: begin
            state_nxt = ST_OFF;
        end
    endcase
    if (!wi_ok) begin
        state_nxt = ST_OFF;
    end
end
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        state_r <= ST_OFF;
        cnt_r <= {CNT_W{1'b0}};
        addr_r <= 12'h000;
        arr_rd <= 1'b0;
        arr_addr <= 12'h000;
        rd_dly_r <= 1'b0;
        rd_addr_dly_r <= 12'h000;
        cache_wr <= 1'b0;
        cache_addr <= 12'h000;
        cache_data <= 8'h00;
        block_bad <= 1'b0;
        rst_cmd_d_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        rst_cmd_d_r <= rst_cmd_ok;
        arr_rd <= (state_r == ST_LOAD); // RULE11
        arr_addr <= addr_r;
        rd_dly_r <= arr_rd;
        rd_addr_dly_r <= arr_addr;
        cache_wr <= rd_dly_r;
        cache_addr <= rd_addr_dly_r;
        cache_data <= arr_data;
        if (state_r == ST_LOAD) begin
            addr_r <= addr_r + 12'h001;
        end else begin
            addr_r <= 12'h000;
        end
        if (state_r == ST_OFF || state_r == ST_RDY) begin
            cnt_r <= INIT_CNT;
        end else if (cnt_r != {CNT_W{1'b0}}) begin
            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (rd_dly_r && rd_addr_dly_r == `NPL_SPARE_START) begin
            block_bad <= (arr_data != `NPL_GOOD_MARK); // RULE4
        end
    end
end
// ----------------------------------------
// Busy flag, held until the page sits in the cache and the init count has run out
// ----------------------------------------
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        busy_in_progress_flag <= 1'b1;
    end else begin
        busy_in_progress_flag <= (state_nxt != ST_RDY); // RULE14
    end
end
// ----------------------------------------
// Status read, served while busy too
// ----------------------------------------
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        status_q <= 8'h00;
        status_vld <= 1'b0;
    end else begin
        status_vld <= status_rd; // RULE12
        if (status_rd) begin
            status_q <= 8'h00;
            status_q[`NPL_STAT_BUSY_BIT] <= busy_in_progress_flag; // RULE14
        end
    end
end
// ----------------------------------------
// Page layout classifier
// ----------------------------------------
reg cov_nxt;
reg ref_nxt;
reg [1:0] sec_nxt;
always @* begin
    cov_nxt = 1'b0;
    ref_nxt = 1'b0;
    sec_nxt = 2'h0;
    if (chk_addr < `NPL_SPARE_START) begin
        cov_nxt = 1'b1; // RULE3
        sec_nxt = chk_addr[`NPL_MAIN_SECT_HI:`NPL_MAIN_SECT_LO];
    end else if (chk_addr <= `NPL_BBM_LAST) begin
        cov_nxt = 1'b0; // RULE2
    end else if (chk_addr >= `NPL_META1_START && chk_addr < `NPL_ECC_START) begin
        cov_nxt = 1'b1; // RULE3
        sec_nxt = chk_addr[`NPL_META1_SECT_HI:`NPL_META1_SECT_LO];
    end else if (chk_addr >= `NPL_ECC_START && chk_addr <= `NPL_ECC_LAST) begin
        cov_nxt = 1'b1;
        ref_nxt = 1'b1; // RULE1
        sec_nxt = chk_addr[`NPL_ECC_SECT_HI:`NPL_ECC_SECT_LO];
    end else if (chk_addr > `NPL_ECC_LAST) begin
        ref_nxt = 1'b1;
    end
end
always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
        chk_ecc_cov <= 1'b0;
        chk_wr_refused <= 1'b0;
        chk_sector <= 2'h0;
    end else begin
        chk_ecc_cov <= cov_nxt;
        chk_wr_refused <= ref_nxt;
        chk_sector <= sec_nxt;
    end
end
endmodule // npl_nand_powerup

// [npl_arr_model.sv]
`timescale 1ns/1ps
module npl_arr_model (
    // Array read port
    input wire clk_sys,
    input wire arr_rd,
    input wire [11:0] arr_addr,
    input wire bad,
    output reg [7:0] arr_data
);
    initial arr_data = 8'h00;
    always @(posedge clk_sys) begin
        if (arr_rd) arr_data <= (arr_addr == 12'h800) ? {8{~bad}} : arr_addr[7:0] ^ 8'h5a;
        else arr_data <= ~arr_data;
    end
endmodule // npl_arr_model

// [npl_nand_powerup_assertions.sv]
`timescale 1ns/1ps
module npl_chk (
    // Watched ports
    input wire clk_sys,
    input wire rst_b,
    input wire write_inhibit_level,
    input wire status_rd,
    input wire [7:0] status_q,
    input wire status_vld,
    input wire arr_rd,
    input wire [11:0] arr_addr,
    input wire cache_wr,
    input wire [11:0] cache_addr,
    input wire [11:0] chk_addr,
    input wire chk_ecc_cov,
    input wire chk_wr_refused,
    input wire [1:0] chk_sector,
    input wire busy_in_progress_flag
);
    reg v_r;
    reg [11:0] pa_r;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) v_r <= 1'b0;
        else v_r <= 1'b1;
    end
    always @(posedge clk_sys) pa_r <= chk_addr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_cache; ##2 cache_wr && cache_addr == $past(arr_addr, 2); endsequence
    sequence s_steady; status_rd ##1 $stable(busy_in_progress_flag); endsequence
    property p_pair; arr_rd |-> s_cache; endproperty
    property p_stat; s_steady |-> status_vld && status_q == {7'h00, busy_in_progress_flag}; endproperty
    property p_ref; v_r |-> chk_wr_refused == (pa_r >= 12'h840); endproperty
    property p_cov; v_r && pa_r <= 12'h87f |-> chk_ecc_cov == (pa_r < 12'h800 || pa_r >= 12'h820);
    endproperty
    property p_sect; v_r && pa_r >= 12'h840 && pa_r <= 12'h87f |-> chk_sector == pa_r[5:4]; endproperty
    property p_busy; arr_rd |-> busy_in_progress_flag; endproperty
    property p_seq; arr_rd && $past(arr_rd) |-> arr_addr == $past(arr_addr) + 12'h001; endproperty
    property p_start; $rose(write_inhibit_level) |-> ##[1:8] (arr_rd && arr_addr == 12'h000);
    endproperty
    a_pair: assert property (p_pair) else $error("cache write misplaced");
    a_stat: assert property (p_stat) else $error("status byte wrong");
    a_ref: assert property (p_ref) else $error("refusal wrong");
    a_cov: assert property (p_cov) else $error("coverage wrong");
    a_sect: assert property (p_sect) else $error("parity sector wrong");
    a_busy: assert property (p_busy) else $error("ready during load");
    a_seq: assert property (p_seq) else $error("load order wrong");
    a_start: assert property (p_start) else $error("no self start");
endmodule // npl_chk

// [npl_nand_powerup_tb.sv]
`timescale 1ns/1ps
module npl_nand_powerup_tb;
    reg clk_sys, rst_b, write_inhibit_level, reset_cmd, status_rd, bad;
    reg [11:0] chk_addr, a;
    wire [7:0] arr_data, status_q, cache_data;
    wire [11:0] arr_addr, cache_addr;
    wire [1:0] chk_sector;
    wire status_vld, arr_rd, cache_wr, chk_ecc_cov, chk_wr_refused, block_bad, busy_in_progress_flag;
    integer n_fail = 0, tests_run = 0, i, k;
    integer n_bad = 0;
    localparam integer T_WI = (250 * 1000 + 99) / 100;
    localparam integer T_POR = (1250 * 1000 + 99) / 100;
    localparam integer total_block_count = 2048;
    localparam integer min_valid_block_count = 2008;
    reg [7:0] q_st[$], q_ck[$];
    reg [19:0] q_ca[$];
    localparam [155:0] TBL = {12'h000, 12'h7ff, 12'h800, 12'h803, 12'h804, 12'h81f, 12'h820,
        12'h83f, 12'h840, 12'h84f, 12'h850, 12'h87f, 12'hfff};
    npl_nand_powerup #(.INIT_CYCLES(20)) npl_nand_powerup_i (.clk_sys, .rst_b,
        .write_inhibit_level, .reset_cmd, .status_rd, .status_q, .status_vld, .arr_rd,
        .arr_addr, .arr_data, .cache_wr, .cache_addr, .cache_data, .chk_addr, .chk_ecc_cov,
        .chk_wr_refused, .chk_sector, .block_bad, .busy_in_progress_flag);
    npl_arr_model npl_arr_model_i (.clk_sys, .arr_rd, .arr_addr, .bad, .arr_data);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task close_out;
        begin
            if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task rep(input [19:0] g, input [19:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t %h %h", $time, g, e);
            end
        end
    endtask
    task cmp_st(input [7:0] g); rep({12'h000, g}, {12'h000, q_st.pop_front()}); endtask
    task cmp_ca(input [19:0] g); rep(g, q_ca.pop_front()); endtask
    task cmp_ck(input [3:0] g);
        reg [7:0] e;
        begin
            e = q_ck.pop_front();
            rep({16'h0000, g & e[7:4]}, {16'h0000, e[3:0]});
        end
    endtask
    always @(negedge clk_sys) begin
        if (status_vld === 1'b1) cmp_st(status_q);
        if (cache_wr === 1'b1) cmp_ca({cache_addr, cache_data});
        if (q_ck.size() > 0) cmp_ck({chk_ecc_cov, chk_wr_refused, chk_sector});
    end
    task status(input [7:0] e);
        begin
            @(posedge clk_sys) status_rd <= 1'b1;
            q_st.push_back(e);
            @(posedge clk_sys) status_rd <= 1'b0;
        end
    endtask
    task wait_busy(input v);
        begin
            for (k = 0; busy_in_progress_flag !== v && k < 3000; k = k + 1) @(negedge clk_sys);
            if (k == 3000) begin
                n_fail = n_fail + 1;
                close_out;
            end
        end
    endtask
    task load(input b);
        for (i = 0; i < 2176; i = i + 1) begin
            a = i;
            q_ca.push_back({a, a == 12'h800 ? {8{~b}} : a[7:0] ^ 8'h5a});
        end
    endtask
    task power(input b);
        begin
            @(posedge clk_sys) bad <= b;
            load(b);
            write_inhibit_level <= 1'b1;
            status(8'h01);
            wait_busy(1'b0);
            status(8'h00);
            rep({19'h0, block_bad}, {19'h0, b});
            if (block_bad === 1'b1) n_bad = n_bad + 1;
            rep({19'h0, (n_bad <= total_block_count - min_valid_block_count)}, 20'h00001);
        end
    endtask
    task chk(input [11:0] x);
        reg [3:0] e, m;
        begin
            e = {x < 12'h800 || (x >= 12'h820 && x <= 12'h87f), x >= 12'h840,
                x < 12'h800 ? x[10:9] : x >= 12'h840 ? x[5:4] : x[4:3]};
            m = {x <= 12'h87f, 1'b1, {2{x < 12'h800 || (x >= 12'h820 && x <= 12'h87f)}}};
            @(posedge clk_sys) chk_addr <= x;
            @(posedge clk_sys) q_ck.push_back({m, e & m});
        end
    endtask
    initial begin
        rst_b = 1'b0; write_inhibit_level = 1'b0; reset_cmd = 1'b0;
        status_rd = 1'b0; chk_addr = 12'h000; bad = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        k = $urandom(80);
        rep({19'h0, busy_in_progress_flag}, 20'h00001);
        power(1'b0);
        @(posedge clk_sys) write_inhibit_level <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rep({19'h0, busy_in_progress_flag}, 20'h00001);
        power(1'b1);
        repeat (T_WI) @(posedge clk_sys);
        load(1'b1);
        @(posedge clk_sys) reset_cmd <= 1'b1;
        repeat (8) @(posedge clk_sys);
        status(8'h01);
        wait_busy(1'b0);
        status(8'h00);
        reset_cmd <= 1'b0;
        @(posedge clk_sys) write_inhibit_level <= 1'b0;
        repeat (10) @(posedge clk_sys);
        load(1'b1);
        write_inhibit_level <= 1'b1;
        repeat (T_POR) @(posedge clk_sys);
        status(8'h00);
        for (i = 0; i < 40; i = i + 1) chk(i < 13 ? TBL[i*12 +: 12] : $urandom % 12'h880);
        repeat (4) @(posedge clk_sys);
        close_out;
    end
endmodule // npl_nand_powerup_tb
bind npl_nand_powerup npl_chk npl_chk_i (.clk_sys, .rst_b, .write_inhibit_level, .status_rd,
    .status_q, .status_vld, .arr_rd, .arr_addr, .cache_wr, .cache_addr, .chk_addr, .chk_ecc_cov,
    .chk_wr_refused, .chk_sector, .busy_in_progress_flag);
